// ### dv/adcc_chk.sv
`timescale 1ns/1ns
// watches the apb side and the sequencer outputs of the top module
module adcc_chk #(
  parameter int unsigned RC_PERIOD_CYCLES = 80,
  parameter int unsigned CONV_PERIODS = 12
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic converter_power_on,
  input wire logic conversion_busy,
  input wire logic conversion_done_flag,
  input wire adcc_pkg::adcc_pins_t pin_config
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // access phase decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rdx = acc & ~pwrite;
  wire ctl = paddr == 12'h07c;
  wire cfg = paddr == 12'h27c;
  // busy run length, so the minimum length can be judged at completion
  int unsigned bcnt;
  always_ff @(posedge mclk) bcnt <= conversion_busy ? bcnt + 1 : 0;
  property p_start;
    wr && ctl && pwdata[2] && pwdata[0] && converter_power_on
      && !conversion_busy |=> conversion_busy;
  endproperty
  a_start: assert property (p_start) else $error("go did not start");
  property p_unpw;
    wr && ctl && !pwdata[0] |=> !conversion_busy;
  endproperty
  a_unpw: assert property (p_unpw) else $error("unpowered busy");
  property p_pwr;
    conversion_busy |-> converter_power_on;
  endproperty
  a_pwr: assert property (p_pwr) else $error("busy while off");
  property p_rd0;
    rdx && ctl |-> prdata[1] == 1'b0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("control bit 1 set");
  property p_rd1;
    rdx && cfg |-> prdata[5:4] == 2'b00;
  endproperty
  a_rd1: assert property (p_rd1) else $error("config bits 5-4 set");
  property p_done;
    $rose(conversion_done_flag) |-> $past(conversion_busy) && !conversion_busy;
  endproperty
  a_done: assert property (p_done) else $error("done apart from end");
  property p_len;
    $rose(conversion_done_flag) |-> $past(bcnt) >= 2 * CONV_PERIODS - 1;
  endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_abort;
    wr && ctl && !pwdata[2] && conversion_busy |=> !conversion_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_pins;
    $fell(reset) |-> pin_config.analog_pins == 8'hff;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not analog");
endmodule : adcc_chk

bind adcc_top adcc_chk #(
  .RC_PERIOD_CYCLES(RC_PERIOD_CYCLES),
  .CONV_PERIODS(CONV_PERIODS)
) adcc_chk_inst (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .converter_power_on(converter_power_on),
  .conversion_busy(conversion_busy),
  .conversion_done_flag(conversion_done_flag), .pin_config(pin_config)
);

// ### dv/test_adc_conversion_control.sv
`timescale 1ns/1ns
module test_adc_conversion_control;
  localparam int RC = 3; // short rc period keeps the run brief
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, j, pwr, sh, done, busy;
  logic comparator_high = 1'b0;
  logic [2:0] chan, s;
  logic [9:0] trial_code;
  logic [9:0] ana = 10'h000; // level the comparator stands for
  logic [15:0] r;
  adcc_pkg::adcc_pins_t pin_config;
  int fails = 0, compares = 0, cyc = 0, n = 0;
  int seed = 32'h1ca1ffc7;
  adcc_top #(.RC_PERIOD_CYCLES(RC), .CONV_PERIODS(12)) adcc_top_inst (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .comparator_high(comparator_high), .converter_power_on(pwr),
    .channel_select(chan), .sample_hold(sh), .trial_code(trial_code),
    .pin_config(pin_config), .conversion_done_flag(done),
    .conversion_busy(busy));
  initial forever #25 mclk = ~mclk;
  // comparator lags one cycle; a bit period is at least two
  always @(posedge mclk) comparator_high <= trial_code <= ana;
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task final_report();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // one apb transfer; returns on the edge that completes it
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    // only the hang guard ends a wait that never completes
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // bit period in clocks for a clock select code
  function int dv(input logic [2:0] c);
    if (c[1:0] == 2'b11) return RC;
    return (c[2] ? 4 : 2) << (2 * c[1:0]);
  endfunction : dv
  // result pair image for a justify choice
  function logic [15:0] jf(input logic jj, input logic [9:0] v);
    return jj ? {6'h00, v} : {v, 6'h00};
  endfunction : jf
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    chk(pin_config, {8'hff, 2'b00, 4'h8});
    apb(1'b1, 12'h27c, 8'hff);
    apb(1'b0, 12'h27c, 8'h00);
    chk(rd, 32'hcf);
    apb(1'b1, 12'h07c, 8'hfe);
    apb(1'b0, 12'h07c, 8'h00);
    chk(rd & 32'h3, 32'h0);
    chk(busy, 1'b0);
    // every port configuration code
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h27c, c[7:0]);
      repeat (2) @(posedge mclk);
      chk(pin_config.analog_count, 64'h8754320066543211 >> (60 - 4 * c) & 15);
      chk(pin_config.vref_high_pin, 16'hbd2a >> c & 1);
      chk(pin_config.vref_low_pin, 16'hb900 >> c & 1);
      if (c == 0 || c[3:1] == 3'b011) chk(pin_config.analog_pins, c ? 0 : 8'hff);
    end
    // one conversion for each clock select except 3'b111, justify alternating
    for (int k = 0; k < 7; k++) begin
      s = 21'o0124563 >> (18 - 3 * k);
      j = k[0];
      ana = k == 0 ? 10'h3ff : k == 1 ? 10'h000 : 10'($random(seed));
      apb(1'b1, 12'h27c, {j, s[2], 6'h00});
      apb(1'b1, 12'h07c, {s[1:0], k[2:0], 3'b001});
      // all-analog pins, acquisition wait before go
      repeat (4) @(posedge mclk);
      chk(sh, 1'b1);
      apb(1'b1, 12'h07c, {s[1:0], k[2:0], 3'b101});
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (done !== 1'b1 && n < 3000);
      chk(n, 12 * dv(s));
      chk(chan, k[2:0]);
      apb(1'b0, 12'h07c, 8'h00);
      chk(rd & 32'h4, 32'h0);
      r = jf(j, ana);
      apb(1'b0, 12'h078, 8'h00);
      chk(rd, r[15:8]);
      apb(1'b0, 12'h278, 8'h00);
      chk(rd, r[7:0]);
      apb(1'b0, 12'h080, 8'h00);
      chk(rd, 32'h1);
      apb(1'b1, 12'h080, 8'h00);
    end
    // abort part way through a slow conversion
    apb(1'b1, 12'h07c, 8'h85);
    repeat (40) @(posedge mclk);
    chk({busy, sh}, 2'b10);
    apb(1'b1, 12'h07c, 8'h81);
    repeat (400) @(posedge mclk);
    #1;
    chk({busy, done}, 2'b00);
    apb(1'b0, 12'h078, 8'h00);
    chk(rd, r[15:8]);
    apb(1'b0, 12'h000, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // go with power cleared: shuts down, starts nothing
    apb(1'b1, 12'h07c, 8'h84);
    @(posedge mclk);
    #1;
    chk({busy, pwr}, 2'b00);
    final_report();
  end
endmodule : test_adc_conversion_control

// ### verilog/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// register indices; byte address is four times the index
`define ADCC_IDX_RES_HIGH 8'h1e
`define ADCC_IDX_CTRL_A 8'h1f
`define ADCC_IDX_RES_LOW 8'h9e
`define ADCC_IDX_CONFIG 8'h9f
`define ADCC_IDX_STATUS 8'h20
// reset values and readable-bit masks
`define ADCC_CTRL_RESET 8'h00
`define ADCC_CFG_RESET 8'h00
`define ADCC_CTRL_MASK 8'hfd
`define ADCC_CFG_MASK 8'hcf
// field positions
`define ADCC_GO_BIT 2
`define ADCC_PWR_BIT 0
`define ADCC_DONE_BIT 0
// timing
`define ADCC_CONV_PERIODS 12
`define ADCC_CLK_PERIOD_NS 50
`define ADCC_RC_PERIOD_NS 4000
`define ADCC_RC_PERIOD_CYCLES (`ADCC_RC_PERIOD_NS / `ADCC_CLK_PERIOD_NS)
`endif

// ### verilog/adcc_pkg.sv
package adcc_pkg;
  // first control register layout
  typedef struct packed {
    logic [1:0] conv_clock_sel_low;
    logic [2:0] channel_select;
    logic convert_go;
    logic spare;
    logic module_power_on;
  } adcc_ctrl_t;
  // configuration register layout
  typedef struct packed {
    logic result_justify_select;
    logic conv_clock_sel_high;
    logic [1:0] spare;
    logic [3:0] port_config_field;
  } adcc_cfg_t;
  // pin and reference steering handed to the pads
  typedef struct packed {
    logic [7:0] analog_pins;
    logic vref_high_pin;
    logic vref_low_pin;
    logic [3:0] analog_count;
  } adcc_pins_t;
  // conversion sequencer
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;
endpackage : adcc_pkg

// ### verilog/adcc_top.sv
`timescale 1ns/1ns
`include "adcc_map.svh"
module adcc_top #(
  parameter int unsigned RC_PERIOD_CYCLES = `ADCC_RC_PERIOD_CYCLES,
  parameter int unsigned CONV_PERIODS = `ADCC_CONV_PERIODS
) (
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end
  input wire logic comparator_high,
  output logic converter_power_on,
  output logic [2:0] channel_select,
  output logic sample_hold,
  output logic [9:0] trial_code,
  output adcc_pkg::adcc_pins_t pin_config,
  // status toward the system
  output logic conversion_done_flag,
  output logic conversion_busy
);

  // refuse settings the counters cannot hold
  if (RC_PERIOD_CYCLES < 2 || RC_PERIOD_CYCLES > 127) begin : g_rc_chk
    $error("rc bit period out of range");
  end
  if (CONV_PERIODS < 12 || CONV_PERIODS > 15) begin : g_len_chk
    $error("conversion length out of range");
  end

  // software-visible state
  adcc_pkg::adcc_ctrl_t ctrl;
  adcc_pkg::adcc_cfg_t cfg;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  adcc_pkg::adcc_state_t state;
  // bit-period divider and period index
  logic [6:0] bp_cnt;
  logic [3:0] bp_idx;

  // apb phase decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  // word aligned, inside the 1 KiB window
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire [7:0] idx = paddr[9:2];
  wire hit_rh = aligned && (idx == `ADCC_IDX_RES_HIGH);
  wire hit_ctrl = aligned && (idx == `ADCC_IDX_CTRL_A);
  wire hit_rl = aligned && (idx == `ADCC_IDX_RES_LOW);
  wire hit_cfg = aligned && (idx == `ADCC_IDX_CONFIG);
  wire hit_st = aligned && (idx == `ADCC_IDX_STATUS);
  wire mapped = hit_rh | hit_ctrl | hit_rl | hit_cfg | hit_st;

  // zero wait states; unmapped answers with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // per-register write strobes
  wire wr_ctrl = wr_en & hit_ctrl;
  wire wr_cfg = wr_en & hit_cfg;
  wire wr_rh = wr_en & hit_rh;
  wire wr_rl = wr_en & hit_rl;
  wire wr_st = wr_en & hit_st;

  // fields of the incoming write
  wire wd_go = pwdata[`ADCC_GO_BIT];
  wire wd_pwr = pwdata[`ADCC_PWR_BIT];
  wire busy = (state == adcc_pkg::ADCC_CONV);

  // start only with power already on; a write that
  // powers up in the same beat does not start
  wire start = wr_ctrl & wd_go & wd_pwr & ~busy
             & ctrl.module_power_on;
  // clearing go or power mid-conversion aborts
  wire abort = busy & wr_ctrl & (~wd_go | ~wd_pwr);

  // bit period in mclk cycles from the 3-bit select
  function automatic logic [6:0] bp_div(
    input logic hi,
    input logic [1:0] lo
  );
    logic [6:0] d;
    d = 7'h02;
    unique case ({hi, lo})
      3'b000: d = 7'h02;
      3'b001: d = 7'h08;
      3'b010: d = 7'h20;
      3'b100: d = 7'h04;
      3'b101: d = 7'h10;
      3'b110: d = 7'h40;
      // x11: free-running rc stand-in
      default: d = RC_PERIOD_CYCLES[6:0];
    endcase
    return d;
  endfunction : bp_div

  // selected period, minus one for the compare
  wire [6:0] div_val = bp_div(cfg.conv_clock_sel_high,
                              ctrl.conv_clock_sel_low);
  wire [6:0] div_last = div_val - 7'h01;
  wire bp_tick = busy && (bp_cnt == div_last);
  wire [3:0] bp_final = CONV_PERIODS[3:0] - 4'h1;
  wire last_bp = (bp_idx == bp_final);
  // completion at the end of the last bit period
  wire finish = bp_tick & last_bp & ~abort;

  // successive approximation: period k tests bit 10-k
  wire in_bits = (bp_idx != 4'h0) && (bp_idx <= 4'ha);
  wire [3:0] shamt = bp_idx - 4'h1;
  wire [9:0] cur_mask = in_bits ? (10'h200 >> shamt) : 10'h000;
  wire [9:0] keep_bit = comparator_high ? cur_mask : 10'h000;
  wire [9:0] next_trial = (bp_idx == 4'h0) ? 10'h200 :
    ((trial_code & ~cur_mask) | keep_bit | (cur_mask >> 1));

  // result formatting by justify select
  wire [7:0] fmt_high = cfg.result_justify_select ?
    {6'h00, trial_code[9:8]} :
    trial_code[9:2];
  wire [7:0] fmt_low = cfg.result_justify_select ?
    trial_code[7:0] :
    {trial_code[1:0], 6'h00};

  // next control value: go follows start, abort, finish
  wire next_go = finish ? 1'b0 :
    (wr_ctrl ? (busy ? ~abort : start) : ctrl.convert_go);
  // one driver for the whole word; bit 1 always low
  adcc_pkg::adcc_ctrl_t next_ctrl;
  assign next_ctrl = wr_ctrl ?
    {pwdata[7:3], next_go, 1'b0, wd_pwr} :
    {ctrl[7:3], next_go, 1'b0, ctrl.module_power_on};

  // next configuration; spare bits forced low
  wire [7:0] cfg_in = pwdata[7:0] & `ADCC_CFG_MASK;
  wire [7:0] next_cfg = wr_cfg ? cfg_in : cfg;

  // completion outranks a software write
  wire [7:0] next_rh = finish ? fmt_high :
    (wr_rh ? pwdata[7:0] : result_high_byte);
  wire [7:0] next_rl = finish ? fmt_low :
    (wr_rl ? pwdata[7:0] : result_low_byte);

  // done flag: set beats a software clear
  wire clr_done = wr_st & ~pwdata[`ADCC_DONE_BIT];
  wire next_done = finish |
    (conversion_done_flag & ~clr_done);

  // sequencer next state
  adcc_pkg::adcc_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      adcc_pkg::ADCC_IDLE: begin
        if (start) begin
          next_state = adcc_pkg::ADCC_CONV;
        end
      end
      adcc_pkg::ADCC_CONV: begin
        if (finish || abort) begin
          next_state = adcc_pkg::ADCC_IDLE;
        end
      end
      default: begin
        next_state = adcc_pkg::ADCC_IDLE;
      end
    endcase
  end

  // pin steering per port configuration code
  function automatic adcc_pkg::adcc_pins_t pin_map(
    input logic [3:0] code
  );
    adcc_pkg::adcc_pins_t p;
    logic [3:0] n;
    p = '0;
    n = 4'h0;
    unique case (code)
      4'h0: p.analog_pins = 8'hff;
      4'h1: p.analog_pins = 8'hf7;
      4'h2: p.analog_pins = 8'h1f;
      4'h3: p.analog_pins = 8'h17;
      4'h4: p.analog_pins = 8'h0b;
      4'h5: p.analog_pins = 8'h03;
      4'h6, 4'h7: p.analog_pins = 8'h00;
      4'h8: p.analog_pins = 8'hf3;
      4'h9: p.analog_pins = 8'h3f;
      4'ha: p.analog_pins = 8'h37;
      4'hb: p.analog_pins = 8'h33;
      4'hc: p.analog_pins = 8'h13;
      4'hd: p.analog_pins = 8'h03;
      4'he: p.analog_pins = 8'h01;
      4'hf: p.analog_pins = 8'h01;
    endcase
    // pin three is the high reference for these codes
    unique case (code)
      4'h1, 4'h3, 4'h5, 4'h8, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf:
        p.vref_high_pin = 1'b1;
      default: p.vref_high_pin = 1'b0;
    endcase
    // pin two is the low reference for these codes
    unique case (code)
      4'h8, 4'hb, 4'hc, 4'hd, 4'hf: p.vref_low_pin = 1'b1;
      default: p.vref_low_pin = 1'b0;
    endcase
    // reference pins are already absent from the mask
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, p.analog_pins[i]};
    end
    p.analog_count = n;
    return p;
  endfunction : pin_map

  wire adcc_pkg::adcc_pins_t next_pins =
    pin_map(next_cfg[3:0]);

  // read mux; unimplemented bits come back zero
  wire [7:0] st_word = {7'h00, conversion_done_flag};
  wire [7:0] rd_byte =
    hit_ctrl ? (ctrl & `ADCC_CTRL_MASK) :
    hit_cfg ? (cfg & `ADCC_CFG_MASK) :
    hit_rh ? result_high_byte :
    hit_rl ? result_low_byte :
    hit_st ? st_word : 8'h00;

  // control registers; reset returns pins to analog
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= `ADCC_CTRL_RESET;
      cfg <= `ADCC_CFG_RESET;
      state <= adcc_pkg::ADCC_IDLE;
      conversion_done_flag <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      state <= next_state;
      conversion_done_flag <= next_done;
    end
  end

  // result pair; cleared at reset so reads are defined
  always_ff @(posedge mclk) begin
    if (reset) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else begin
      result_high_byte <= next_rh;
      result_low_byte <= next_rl;
    end
  end

  // bit-period divider, restarted on every start
  always_ff @(posedge mclk) begin
    if (reset || !busy || start) begin
      bp_cnt <= 7'h00;
      bp_idx <= 4'h0;
    end else if (bp_tick) begin
      bp_cnt <= 7'h00;
      bp_idx <= bp_idx + 4'h1;
    end else begin
      bp_cnt <= bp_cnt + 7'h01;
    end
  end

  // trial code to the dac; cleared at each start
  always_ff @(posedge mclk) begin
    if (reset || start) begin
      trial_code <= 10'h000;
    end else if (bp_tick) begin
      trial_code <= next_trial;
    end
  end

  // pad steering registered so pins never glitch
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_config <= pin_map(4'h0);
    end else begin
      pin_config <= next_pins;
    end
  end

  // read data captured in the setup beat
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // front-end controls straight from registers
  assign converter_power_on = ctrl.module_power_on;
  assign channel_select = ctrl.channel_select;
  assign conversion_busy = busy;
  // track while idle and powered and through bit period 0, hold from period 1
  assign sample_hold = ctrl.module_power_on &
    (~busy | (bp_idx == 4'h0));

endmodule : adcc_top
